// file: verilog/mwbm_pkg.sv
// Shared constants and types of the microword and block move unit
package mwbm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DW = 16;
  localparam int UA_W = 9;
  localparam int SA_W = 9;
  localparam int STK_DEPTH = 4;
  localparam int SP_W = 3;

  // ****************************************
  // Special action bit positions
  // ****************************************
  localparam int SA_PC_LOAD = 0;
  localparam int SA_SC_LOAD = 1;
  localparam int SA_OPR_LOAD = 2;
  localparam int SA_PC_INC = 3;
  localparam int SA_SC_STEP = 4;
  localparam int SA_OPR_SHIFT = 5;
  localparam int SA_BUF_TO_IR = 6;
  localparam int SA_STK_INSERT = 7;
  localparam int SA_STK_DISCARD = 8;

  // ****************************************
  // Reset values and full stack pointer
  // ****************************************
  localparam logic [DW-1:0] WORD_RST = 16'h0000;
  localparam logic [UA_W-1:0] UADDR_RST = 9'h000;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;
  localparam logic [SP_W-1:0] SP_FULL = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_PAGE_JUMP = 2'b00,
    MODE_BRANCH_ON_TRUE = 2'b01,
    MODE_BRANCH_ON_FALSE = 2'b10,
    MODE_STACK_RETURN_BRANCH = 2'b11
  } mwbm_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ENTRY = 4'b0001,
    ST_SAVE_PC = 4'b0010,
    ST_DEC_TO = 4'b0011,
    ST_SET_PC = 4'b0100,
    ST_FETCH = 4'b0101,
    ST_COUNT = 4'b0110,
    ST_TEST = 4'b0111,
    ST_EXIT = 4'b1000,
    ST_REFILL = 4'b1001,
    ST_DECODE = 4'b1010
  } mwbm_state_e;

endpackage

// file: verilog/mwbm_shcnt.sv
// Shift counter with all-ones flag
module mwbm_shcnt
  import mwbm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [DW-1:0] value_i,
  output logic [DW-1:0] count_o,
  output logic full_o
);

  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  logic full_q;
  logic full_d;

  // ****************************************
  // Next value
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = value_i;
    end else if (step_i) begin
      cnt_d = cnt_q + 16'h0001;
    end
    full_d = &cnt_d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_q <= WORD_RST;
      full_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      full_q <= full_d;
    end
  end

  assign count_o = cnt_q;
  assign full_o = full_q;

endmodule

// file: verilog/mwbm_useq.sv
// Microaddress sequencer with return stack
module mwbm_useq
  import mwbm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic valid_i,
  input wire logic [1:0] mode_i,
  input wire logic cond_i,
  input wire logic [UA_W-1:0] pass_i,
  input wire logic [UA_W-1:0] fail_i,
  input wire logic insert_i,
  input wire logic discard_i,
  input wire logic [UA_W-1:0] insert_val_i,
  output logic [UA_W-1:0] uaddr_o,
  output logic [SP_W-1:0] depth_o
);

  logic [UA_W-1:0] stk_q [STK_DEPTH];
  logic [UA_W-1:0] stk_d [STK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;
  logic [UA_W-1:0] ua_q;
  logic [UA_W-1:0] ua_d;
  logic [UA_W-1:0] top;
  logic page_jump;

  // ****************************************
  // Next microaddress and stack
  // ****************************************
  always_comb begin
    stk_d = stk_q;
    sp_d = sp_q;
    ua_d = ua_q;
    page_jump = (mode_i == MODE_PAGE_JUMP);
    top = (sp_q != SP_RST) ? stk_q[sp_q[1:0] - 2'h1] : UADDR_RST;
    if (valid_i) begin
      case (mode_i)
        MODE_PAGE_JUMP: begin
          ua_d = pass_i;
        end
        MODE_BRANCH_ON_TRUE: begin
          ua_d = cond_i ? pass_i : fail_i;
        end
        MODE_BRANCH_ON_FALSE: begin
          ua_d = cond_i ? fail_i : pass_i;
        end
        default: begin
          ua_d = top;
          if (sp_q != SP_RST) begin
            sp_d = sp_q - 3'h1;
          end
        end
      endcase
      if (page_jump && insert_i && sp_q != SP_FULL) begin
        stk_d[sp_q[1:0]] = insert_val_i;
        sp_d = sp_q + 3'h1;
      end else if (page_jump && discard_i && sp_q != SP_RST) begin
        sp_d = sp_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_q[i] <= UADDR_RST;
      end
      sp_q <= SP_RST;
      ua_q <= UADDR_RST;
    end else begin
      stk_q <= stk_d;
      sp_q <= sp_d;
      ua_q <= ua_d;
    end
  end

  assign uaddr_o = ua_q;
  assign depth_o = sp_q;

endmodule

// file: verilog/mwbm_top.sv
// Microword special actions and memory-to-memory block copy engine
//
// Behaviour
// - pc_load_from_alu loads the program counter from the ALU output.
// - shift_count_load loads the shift counter; shift_count_step increments it.
// - operand_reg_load loads the operand register; may combine with pc_increment.
// - pc_increment adds one to the program counter.
// - operand_shift moves operand one bit left or right, with supplied end bits.
// - buffer_to_instr_reg copies the instruction buffer into the instruction register.
// - stack insert pushes a value, only under page_jump addressing.
// - stack_discard_top drops the top entry, only under page_jump addressing.
// - branch_on_true/false take pass or fail address from the condition.
// - stack_return_branch jumps to the stack top and pops it.
// - shift_count_full_flag is set when the shift counter is all ones.
// - Copy moves count words, ascending, from source to destination.
// - Copy saves PC then sets PC to source minus one.
// - Source and destination are decremented once before the loop.
// - copy_loop_fetch increments source, reads it, drives latch for pending store.
// - Second loop word decrements and samples the result.
// - Third word increments R0, tests sign, stores and loops while clear.
// - On negative count, leave loop and drop the outstanding read data.
// - copy_exit restores PC fetches, branches to pipeline_refill_state.
// - Refill increments PC and fetches; decode loads IR and returns to ROM.
module mwbm_top
  import mwbm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic uw_valid_i,
  input wire logic [SA_W-1:0] uw_action_i,
  input wire logic [1:0] uw_mode_i,
  input wire logic uw_cond_i,
  input wire logic [UA_W-1:0] uw_pass_i,
  input wire logic [UA_W-1:0] uw_fail_i,
  input wire logic [UA_W-1:0] uw_insert_val_i,
  input wire logic uw_shift_right_i,
  input wire logic uw_shift_hi_i,
  input wire logic uw_shift_lo_i,
  input wire logic [DW-1:0] alu_i,
  input wire logic copy_start_i,
  input wire logic [DW-1:0] gpr_to_i,
  input wire logic [DW-1:0] gpr_from_i,
  input wire logic [DW-1:0] gpr_count_i,
  input wire logic [DW-1:0] mem_rdata_i,
  input wire logic mem_done_i,
  output logic mem_req_o,
  output logic mem_write_o,
  output logic [DW-1:0] mem_addr_o,
  output logic [DW-1:0] mem_wdata_o,
  output logic [DW-1:0] pc_o,
  output logic [DW-1:0] opr_o,
  output logic [DW-1:0] ir_o,
  output logic [DW-1:0] shift_count_o,
  output logic shift_count_full_flag_o,
  output logic [UA_W-1:0] uaddr_o,
  output logic [SP_W-1:0] stack_depth_o,
  output logic copy_busy_o,
  output logic rom_return_o
);

  // ****************************************
  // State
  // ****************************************
  mwbm_state_e st_q;
  mwbm_state_e st_d;
  logic [DW-1:0] pc_q, pc_d, opr_q, opr_d, ir_q, ir_d, ibuf_q, ibuf_d;
  logic [DW-1:0] r0_q, r0_d, r1_q, r1_d, r2_q, r2_d, r7_q, r7_d;
  logic [DW-1:0] latch_q, latch_d, addr_q, addr_d, wdata_q, wdata_d;
  logic [DW-1:0] wr_addr_q, wr_addr_d;
  logic req_q, req_d, we_q, we_d, ifetch_q, ifetch_d;
  logic discard_q, discard_d, wr_pend_q, wr_pend_d, neg_q, neg_d;
  logic busy_q, busy_d, ret_q, ret_d;
  logic uw_go;
  logic port_free;
  logic [DW-1:0] cnt_dec;

  function automatic logic [DW-1:0] wstep(input logic [DW-1:0] a, input logic down);
    wstep = down ? (a - 16'h0001) : (a + 16'h0001);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  assign uw_go = uw_valid_i && (st_q == ST_IDLE);

  mwbm_useq u_useq (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(uw_go),
    .mode_i(uw_mode_i),
    .cond_i(uw_cond_i),
    .pass_i(uw_pass_i),
    .fail_i(uw_fail_i),
    .insert_i(uw_action_i[SA_STK_INSERT]),
    .discard_i(uw_action_i[SA_STK_DISCARD]),
    .insert_val_i(uw_insert_val_i),
    .uaddr_o(uaddr_o),
    .depth_o(stack_depth_o)
  );

  mwbm_shcnt u_shcnt (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .load_i(uw_go && uw_action_i[SA_SC_LOAD]),
    .step_i(uw_go && uw_action_i[SA_SC_STEP]),
    .value_i(alu_i),
    .count_o(shift_count_o),
    .full_o(shift_count_full_flag_o)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    opr_d = opr_q;
    ir_d = ir_q;
    ibuf_d = ibuf_q;
    r0_d = r0_q;
    r1_d = r1_q;
    r2_d = r2_q;
    r7_d = r7_q;
    latch_d = latch_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_addr_d = wr_addr_q;
    req_d = req_q;
    we_d = we_q;
    ifetch_d = ifetch_q;
    discard_d = discard_q;
    wr_pend_d = wr_pend_q;
    neg_d = neg_q;
    ret_d = 1'b0;
    cnt_dec = wstep(r2_q, 1'b1);
    port_free = !req_q;

    // Memory completion; write data stays in wdata_q until here
    if (req_q && mem_done_i) begin
      req_d = 1'b0;
      discard_d = 1'b0;
      if (!we_q && ifetch_q) begin
        ir_d = ibuf_q;
        ibuf_d = mem_rdata_i;
      end else if (!we_q && !discard_q) begin
        latch_d = mem_rdata_i;
      end
    end

    case (st_q)
      ST_IDLE: begin
        if (uw_go) begin
          if (uw_action_i[SA_PC_LOAD]) begin
            pc_d = alu_i;
          end else if (uw_action_i[SA_PC_INC]) begin
            pc_d = wstep(pc_q, 1'b0);
          end
          if (uw_action_i[SA_OPR_LOAD]) begin
            opr_d = alu_i;
          end else if (uw_action_i[SA_OPR_SHIFT]) begin
            opr_d = uw_shift_right_i ? {uw_shift_hi_i, opr_q[DW-1:1]} :
                                       {opr_q[DW-2:0], uw_shift_lo_i};
          end
          if (uw_action_i[SA_BUF_TO_IR]) begin
            ir_d = ibuf_q;
          end
        end else if (copy_start_i) begin
          r0_d = gpr_to_i;
          r1_d = gpr_from_i;
          r2_d = gpr_count_i;
          st_d = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        st_d = ST_SAVE_PC;
      end
      ST_SAVE_PC: begin
        r7_d = pc_q;
        st_d = ST_DEC_TO;
      end
      ST_DEC_TO: begin
        r0_d = wstep(r0_q, 1'b1);
        st_d = ST_SET_PC;
      end
      ST_SET_PC: begin
        pc_d = wstep(r1_q, 1'b1);
        st_d = ST_FETCH;
      end
      ST_FETCH: begin
        if (wr_pend_q && port_free) begin
          req_d = 1'b1;
          we_d = 1'b1;
          ifetch_d = 1'b0;
          addr_d = wr_addr_q;
          wdata_d = latch_q;
          wr_pend_d = 1'b0;
        end else if (!wr_pend_q && port_free) begin
          pc_d = wstep(pc_q, 1'b0);
          req_d = 1'b1;
          we_d = 1'b0;
          ifetch_d = 1'b0;
          addr_d = wstep(pc_q, 1'b0);
          st_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        r2_d = cnt_dec;
        neg_d = cnt_dec[DW-1];
        st_d = ST_TEST;
      end
      ST_TEST: begin
        if (neg_q) begin
          discard_d = req_q && !(mem_done_i);
          st_d = ST_EXIT;
        end else if (port_free) begin
          r0_d = wstep(r0_q, 1'b0);
          wr_addr_d = wstep(r0_q, 1'b0);
          wr_pend_d = 1'b1;
          st_d = ST_FETCH;
        end
      end
      ST_EXIT: begin
        if (port_free) begin
          pc_d = r7_q;
          req_d = 1'b1;
          we_d = 1'b0;
          ifetch_d = 1'b1;
          addr_d = r7_q;
          st_d = ST_REFILL;
        end
      end
      ST_REFILL: begin
        if (port_free) begin
          pc_d = wstep(pc_q, 1'b0);
          req_d = 1'b1;
          we_d = 1'b0;
          ifetch_d = 1'b1;
          addr_d = wstep(pc_q, 1'b0);
          st_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (port_free) begin
          ret_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      pc_q <= WORD_RST;
      opr_q <= WORD_RST;
      ir_q <= WORD_RST;
      ibuf_q <= WORD_RST;
      r0_q <= WORD_RST;
      r1_q <= WORD_RST;
      r2_q <= WORD_RST;
      r7_q <= WORD_RST;
      latch_q <= WORD_RST;
      addr_q <= WORD_RST;
      wdata_q <= WORD_RST;
      wr_addr_q <= WORD_RST;
      req_q <= 1'b0;
      we_q <= 1'b0;
      ifetch_q <= 1'b0;
      discard_q <= 1'b0;
      wr_pend_q <= 1'b0;
      neg_q <= 1'b0;
      busy_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      opr_q <= opr_d;
      ir_q <= ir_d;
      ibuf_q <= ibuf_d;
      r0_q <= r0_d;
      r1_q <= r1_d;
      r2_q <= r2_d;
      r7_q <= r7_d;
      latch_q <= latch_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_addr_q <= wr_addr_d;
      req_q <= req_d;
      we_q <= we_d;
      ifetch_q <= ifetch_d;
      discard_q <= discard_d;
      wr_pend_q <= wr_pend_d;
      neg_q <= neg_d;
      busy_q <= busy_d;
      ret_q <= ret_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mem_req_o = req_q;
  assign mem_write_o = we_q;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign pc_o = pc_q;
  assign opr_o = opr_q;
  assign ir_o = ir_q;
  assign copy_busy_o = busy_q;
  assign rom_return_o = ret_q;

endmodule

// file: tb/mwbm_top_monitor.sv
// Port checker of the microword and block move unit
module mwbm_chk
  import mwbm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic uw_valid_i,
  input wire logic [SA_W-1:0] uw_action_i,
  input wire logic [1:0] uw_mode_i,
  input wire logic uw_cond_i,
  input wire logic [UA_W-1:0] uw_pass_i,
  input wire logic [UA_W-1:0] uw_fail_i,
  input wire logic uw_shift_right_i,
  input wire logic uw_shift_hi_i,
  input wire logic [DW-1:0] alu_i,
  input wire logic mem_done_i,
  input wire logic mem_req_o,
  input wire logic mem_write_o,
  input wire logic [DW-1:0] mem_addr_o,
  input wire logic [DW-1:0] mem_wdata_o,
  input wire logic [DW-1:0] pc_o,
  input wire logic [DW-1:0] opr_o,
  input wire logic [DW-1:0] shift_count_o,
  input wire logic shift_count_full_flag_o,
  input wire logic [UA_W-1:0] uaddr_o,
  input wire logic [SP_W-1:0] stack_depth_o,
  input wire logic copy_busy_o,
  input wire logic rom_return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic g;
  assign g = uw_valid_i && !copy_busy_o;
  property p_pc_load;
    g && uw_action_i[SA_PC_LOAD] |=> pc_o == $past(alu_i);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load");
  property p_pc_inc;
    g && uw_action_i[SA_PC_INC] && !uw_action_i[SA_PC_LOAD] |=> pc_o == $past(pc_o) + 16'h1;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc step");
  property p_sc_load;
    g && uw_action_i[SA_SC_LOAD] |=> shift_count_o == $past(alu_i);
  endproperty
  a_sc_load: assert property (p_sc_load) else $error("count load");
  property p_full;
    shift_count_full_flag_o == (shift_count_o == 16'hFFFF);
  endproperty
  a_full: assert property (p_full) else $error("full flag");
  property p_opr_load;
    g && uw_action_i[SA_OPR_LOAD] |=> opr_o == $past(alu_i);
  endproperty
  a_opr_load: assert property (p_opr_load) else $error("operand load");
  property p_shift_r;
    g && uw_action_i[SA_OPR_SHIFT] && !uw_action_i[SA_OPR_LOAD] && uw_shift_right_i
      |=> opr_o == {$past(uw_shift_hi_i), $past(opr_o[15:1])};
  endproperty
  a_shift_r: assert property (p_shift_r) else $error("right shift");
  property p_branch;
    g && (uw_mode_i[0] ^ uw_mode_i[1]) |=> uaddr_o ==
      (($past(uw_cond_i) ^ $past(uw_mode_i[1])) ? $past(uw_pass_i) : $past(uw_fail_i));
  endproperty
  a_branch: assert property (p_branch) else $error("test branch");
  property p_stk_hold;
    g && (uw_mode_i[0] ^ uw_mode_i[1]) |=> $stable(stack_depth_o);
  endproperty
  a_stk_hold: assert property (p_stk_hold) else $error("stack moved");
  property p_mem_hold;
    mem_req_o && !mem_done_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_wdata_o) && $stable(mem_write_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request moved");
  property p_mem_drop;
    mem_req_o && mem_done_i |=> !mem_req_o;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("request kept");
  c_ret: cover property (rom_return_o);
  c_wr: cover property (mem_req_o && mem_write_o && mem_done_i);
  c_full: cover property (shift_count_full_flag_o);
endmodule

bind mwbm_top mwbm_chk u_chk (.clk_sys_i, .sys_rst_i, .uw_valid_i, .uw_action_i,
  .uw_mode_i, .uw_cond_i, .uw_pass_i, .uw_fail_i, .uw_shift_right_i, .uw_shift_hi_i,
  .alu_i, .mem_done_i, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .pc_o,
  .opr_o, .shift_count_o, .shift_count_full_flag_o, .uaddr_o, .stack_depth_o,
  .copy_busy_o, .rom_return_o);

// file: tb/mwbm_mem.sv
// Behavioural main memory behind the request port
module mwbm_mem (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] lat_i,
  output logic [15:0] rdata_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] m [0:255];
  logic [3:0] cnt;
  int nwr;
  int nrd;
  initial begin
    for (int j = 0; j < 256; j++) begin
      m[j] = 16'hC000 + 16'(j);
    end
  end
  initial done_o = 1'b0;
  initial rdata_o = 16'h5A5A;
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    // Read data is only good in the done cycle
    rdata_o <= ~rdata_o;
    if (sys_rst_i) begin
      cnt <= 4'h0;
      nwr <= 0;
      nrd <= 0;
    end else if (req_i && !done_o) begin
      cnt <= cnt + 4'h1;
      if (cnt == lat_i) begin
        cnt <= 4'h0;
        done_o <= 1'b1;
        if (write_i) begin
          m[addr_i[7:0]] <= wdata_i;
          nwr <= nwr + 1;
        end else begin
          rdata_o <= m[addr_i[7:0]];
          nrd <= nrd + 1;
        end
      end
    end
  end
endmodule

// file: tb/tb_mwbm_top.sv
// Self-checking bench of the microword and block move unit
module tb_mwbm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, sys_rst_i = 1'b1, uw_valid_i = 1'b0, uw_cond_i = 1'b0;
  logic uw_shift_right_i = 1'b0, uw_shift_hi_i = 1'b0, uw_shift_lo_i = 1'b0;
  logic copy_start_i = 1'b0, mem_done_i, mem_req_o, mem_write_o;
  logic shift_count_full_flag_o, copy_busy_o, rom_return_o;
  logic [8:0] uw_action_i = 9'h000, uaddr_o;
  logic [8:0] uw_pass_i = 9'h0AA, uw_fail_i = 9'h055, uw_insert_val_i = 9'h123;
  logic [1:0] uw_mode_i = 2'h0;
  logic [2:0] stack_depth_o;
  logic [3:0] lat = 4'h0;
  logic [15:0] alu_i = 16'h0000, gpr_to_i = 16'h0000, gpr_from_i = 16'h0000;
  logic [15:0] gpr_count_i = 16'h0000, mem_rdata_i, mem_addr_o, mem_wdata_o;
  logic [15:0] pc_o, opr_o, ir_o, shift_count_o;
  int fail_count = 0, n_tests = 0, cyc = 0, i;
  mwbm_top uut (.clk_sys_i, .sys_rst_i, .uw_valid_i, .uw_action_i, .uw_mode_i, .uw_cond_i,
    .uw_pass_i, .uw_fail_i, .uw_insert_val_i, .uw_shift_right_i,
    .uw_shift_hi_i, .uw_shift_lo_i, .alu_i, .copy_start_i, .gpr_to_i, .gpr_from_i,
    .gpr_count_i, .mem_rdata_i, .mem_done_i, .mem_req_o, .mem_write_o, .mem_addr_o,
    .mem_wdata_o, .pc_o, .opr_o, .ir_o, .shift_count_o, .shift_count_full_flag_o, .uaddr_o,
    .stack_depth_o, .copy_busy_o, .rom_return_o);
  mwbm_mem u_mem (.clk_sys_i, .sys_rst_i, .req_i(mem_req_o), .write_i(mem_write_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .lat_i(lat), .rdata_o(mem_rdata_i),
    .done_o(mem_done_i));
  // ****************************************
  // Clock, watchdog and tasks
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic uw(input logic [8:0] a, input logic [1:0] md, input logic c,
    input logic [15:0] v);
    @(posedge clk_sys_i);
    uw_valid_i <= 1'b1;
    uw_action_i <= a;
    uw_mode_i <= md;
    uw_cond_i <= c;
    alu_i <= v;
    @(posedge clk_sys_i);
    uw_valid_i <= 1'b0;
    #1;
  endtask
  task automatic copy(input logic [15:0] d, s, n, input logic [3:0] w);
    int k;
    @(posedge clk_sys_i);
    gpr_to_i <= d;
    gpr_from_i <= s;
    gpr_count_i <= n;
    lat <= w;
    copy_start_i <= 1'b1;
    @(posedge clk_sys_i);
    copy_start_i <= 1'b0;
    #1;
    chk({15'h0, copy_busy_o}, 16'h0001);
    for (k = 0; k < 900 && rom_return_o !== 1'b1; k++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk({15'h0, rom_return_o}, 16'h0001);
    chk({15'h0, copy_busy_o}, 16'h0000);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({15'h0, rom_return_o}, 16'h0000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    uw(9'h001, 2'h0, 1'b0, 16'h0040);
    chk(pc_o, 16'h0040);
    uw(9'h008, 2'h0, 1'b0, 16'h0000);
    chk(pc_o, 16'h0041);
    uw(9'h00C, 2'h0, 1'b0, 16'hA5A5);
    chk(opr_o, 16'hA5A5);
    chk(pc_o, 16'h0042);
    uw_shift_right_i <= 1'b1;
    uw_shift_hi_i <= 1'b1;
    uw(9'h020, 2'h0, 1'b0, 16'h0000);
    chk(opr_o, 16'hD2D2);
    uw_shift_right_i <= 1'b0;
    uw_shift_lo_i <= 1'b1;
    uw(9'h020, 2'h0, 1'b0, 16'h0000);
    chk(opr_o, 16'hA5A5);
    uw(9'h002, 2'h0, 1'b0, 16'hFFFE);
    chk({15'h0, shift_count_full_flag_o}, 16'h0000);
    uw(9'h010, 2'h0, 1'b0, 16'h0000);
    chk(shift_count_o, 16'hFFFF);
    chk({15'h0, shift_count_full_flag_o}, 16'h0001);
    uw(9'h080, 2'h0, 1'b0, 16'h0000);
    chk({13'h0, stack_depth_o}, 16'h0001);
    uw_pass_i <= 9'h092;
    uw(9'h000, 2'h0, 1'b0, 16'h0000);
    chk({7'h0, uaddr_o}, 16'h0092);
    chk({13'h0, stack_depth_o}, 16'h0001);
    uw_pass_i <= 9'h0AA;
    uw(9'h080, 2'h1, 1'b1, 16'h0000);
    chk({13'h0, stack_depth_o}, 16'h0001);
    chk({7'h0, uaddr_o}, 16'h00AA);
    uw(9'h000, 2'h2, 1'b1, 16'h0000);
    chk({7'h0, uaddr_o}, 16'h0055);
    uw_insert_val_i <= 9'h0F0;
    uw(9'h080, 2'h0, 1'b0, 16'h0000);
    chk({13'h0, stack_depth_o}, 16'h0002);
    uw(9'h100, 2'h0, 1'b0, 16'h0000);
    chk({13'h0, stack_depth_o}, 16'h0001);
    uw(9'h000, 2'h3, 1'b0, 16'h0000);
    chk({7'h0, uaddr_o}, 16'h0123);
    chk({13'h0, stack_depth_o}, 16'h0000);
    copy(16'h0080, 16'h0010, 16'h0003, 4'h0);
    for (i = 0; i < 3; i++) chk(u_mem.m[8'h80 + i], 16'hC010 + 16'(i));
    chk(u_mem.m[8'h83], 16'hC083);
    chk(16'(u_mem.nwr), 16'h0003);
    chk(16'(u_mem.nrd), 16'h0006);
    chk(pc_o, 16'h0043);
    chk(ir_o, 16'hC042);
    uw(9'h040, 2'h0, 1'b0, 16'h0000);
    chk(ir_o, 16'hC043);
    copy(16'h00A0, 16'h0020, 16'h0000, 4'h3);
    chk(u_mem.m[8'hA0], 16'hC0A0);
    chk(16'(u_mem.nwr), 16'h0003);
    chk(pc_o, 16'h0044);
    report_and_stop();
  end
endmodule
